// file: dv/host_port_model.sv
// Host model that drives the decoded serial register port
`timescale 1ns/1ns
module host_port_model (
    input  wire logic       clk_sys,
    output logic      [6:0] reg_addr,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_wdata
);
    initial begin
        reg_addr  = 7'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_wdata = 8'h00;
    end

    // One byte access, launched just after an edge and held for one full cycle
    task automatic access(input logic w, input logic [6:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1;
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = w;
        reg_rd    = !w;
        @(posedge clk_sys);
        #1;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        // Released lines show inverted values so stale data cannot pass
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask
endmodule

// file: dv/page_select_and_burst_length_bench.sv
// Self-checking bench for the page select and burst length bank
`timescale 1ns/1ns
module page_select_and_burst_length_bench;
    logic        clk_sys;
    logic        resetn;
    logic [6:0]  reg_addr;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_wdata;
    logic [7:0]  reg_rdata;
    logic        reg_rvalid;
    logic [1:0]  bank_sel;
    logic        rx_burst_valid;
    logic [15:0] rx_burst_length_word;
    logic        rx_buf_wr;
    logic [6:0]  rx_buf_addr;
    logic [7:0]  rx_buf_data;
    logic [6:0]  tx_rd_addr;
    logic [7:0]  tx_rd_data;
    logic [1:0]  tx_professional;
    logic [7:0]  exp_q[$];
    int          n_fail;
    int          num_checks;
    logic [15:0] burst;
    logic [7:0]  d;
    logic [7:0]  crc;
    logic [7:0]  d47;
    logic [6:0]  a;

    page_select_and_burst_length uut (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .bank_sel(bank_sel), .rx_burst_valid(rx_burst_valid),
        .rx_burst_length_word(rx_burst_length_word), .rx_buf_wr(rx_buf_wr), .rx_buf_addr(rx_buf_addr),
        .rx_buf_data(rx_buf_data), .tx_rd_addr(tx_rd_addr), .tx_rd_data(tx_rd_data),
        .tx_professional(tx_professional));

    host_port_model host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic results();
        if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t byte got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_mode(input logic [1:0] got, input logic [1:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t two-bit state got %b expected %b", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        host.access(1'b1, a, v);
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.access(1'b0, a, 8'h00);
    endtask

    task automatic rxw(input logic [6:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        #1;
        rx_buf_wr   = 1'b1;
        rx_buf_addr = a;
        rx_buf_data = v;
        @(posedge clk_sys);
        #1;
        rx_buf_wr   = 1'b0;
        rx_buf_addr = ~a;
        rx_buf_data = ~v;
    endtask

    // Bitwise MSB-first update, kept separate from any design arithmetic
    function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] v);
        logic [7:0] r;
        r = c ^ v;
        for (int k = 0; k < 8; k++) r = r[7] ? ({r[6:0], 1'b0} ^ 8'h1D) : {r[6:0], 1'b0};
        return r;
    endfunction

    // Read results arrive one cycle after the strobe and stand one cycle
    always @(negedge clk_sys) begin
        if (reg_rvalid === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_fail++;
                $display("[FAIL] %0t unexpected read result", $time);
            end else chk_byte(reg_rdata, exp_q.pop_front());
        end
    end

    initial begin
        #200000;
        n_fail++;
        results();
    end

    initial begin
        resetn = 1'b0;
        rx_burst_valid = 1'b0;
        rx_burst_length_word = 16'h0000;
        rx_buf_wr = 1'b0;
        rx_buf_addr = 7'h00;
        rx_buf_data = 8'h00;
        tx_rd_addr = 7'h00;
        n_fail = 0;
        num_checks = 0;
        void'($urandom(32'h7AF1A3D7));
        repeat (8) @(posedge clk_sys);
        #1;
        resetn = 1'b1;
        chk_mode(bank_sel, 2'b00);
        rd(7'h7F, 8'h00);
        burst = 16'($urandom);
        @(posedge clk_sys);
        #1;
        rx_burst_valid = 1'b1;
        rx_burst_length_word = burst;
        @(posedge clk_sys);
        #1;
        rx_burst_valid = 1'b0;
        rx_burst_length_word = ~burst;
        rd(7'h2B, burst[15:8]);
        rd(7'h2C, burst[7:0]);
        rd(7'h10, 8'h00);
        for (int b = 0; b < 4; b++) begin
            wr(7'h7F, {6'($urandom), 2'(b)});
            chk_mode(bank_sel, 2'(b));
            rd(7'h7F, {6'h00, 2'(b)});
        end
        rd(7'h00, 8'h00);
        wr(7'h7F, 8'h01);
        for (int i = 0; i < 6; i++) begin
            a = 7'($urandom % 48) + ((i % 2 == 1) ? 7'h40 : 7'h00);
            d = 8'($urandom);
            rxw(a, d);
            rd(a, d);
        end
        wr(7'h7F, 8'h02);
        crc = 8'hFF;
        for (int n = 0; n < 23; n++) begin
            d = (n == 0) ? (8'($urandom) | 8'h80) : 8'($urandom);
            crc = crc_step(crc, d);
            wr(7'(2 * n), d);
        end
        wr(7'h01, 8'($urandom) & 8'h7F);
        d47 = 8'($urandom);
        wr(7'h2F, d47);
        rd(7'h2F, d47);
        d = 8'($urandom);
        wr(7'h41, d);
        repeat (100) @(posedge clk_sys);
        #1;
        chk_mode(tx_professional, 2'b01);
        tx_rd_addr = 7'h2E;
        @(posedge clk_sys);
        #1;
        chk_byte(tx_rd_data, crc);
        tx_rd_addr = 7'h2F;
        @(posedge clk_sys);
        #1;
        chk_byte(tx_rd_data, d47);
        tx_rd_addr = 7'h41;
        @(posedge clk_sys);
        #1;
        chk_byte(tx_rd_data, d);
        tx_rd_addr = 7'h30;
        @(posedge clk_sys);
        #1;
        chk_byte(tx_rd_data, 8'h00);
        // Mid-run reset must drop the page back to control and status
        resetn = 1'b0;
        @(posedge clk_sys);
        #1;
        resetn = 1'b1;
        chk_mode(bank_sel, 2'b00);
        rd(7'h2F, 8'h00);
        repeat (4) @(posedge clk_sys);
        if (exp_q.size() != 0) chk_byte(8'hFF, 8'h00);
        results();
    end
endmodule

// file: verilog/page_select_and_burst_length.sv
// Host register pages, burst length status and channel status buffers
`timescale 1ns/1ns
module page_select_and_burst_length #(
    parameter int STATUS_BYTES = page_select_pkg::STATUS_BYTES
) (
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    input  wire logic [6:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    output logic             reg_rvalid,
    output logic      [1:0]  bank_sel,
    input  wire logic        rx_burst_valid,
    input  wire logic [15:0] rx_burst_length_word,
    input  wire logic        rx_buf_wr,
    input  wire logic [6:0]  rx_buf_addr,
    input  wire logic [7:0]  rx_buf_data,
    input  wire logic [6:0]  tx_rd_addr,
    output logic      [7:0]  tx_rd_data,
    output logic      [1:0]  tx_professional
);
    localparam int NBYTES = 2 * STATUS_BYTES;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Buffer slot for an in-page address; valid flags a mapped byte
    function automatic logic [7:0] buf_slot(input logic [6:0] a, output logic valid, output logic user);
        logic [6:0] rel;
        rel   = 7'h00;
        valid = 1'b0;
        user  = 1'b0;
        if (a >= page_select_pkg::OFS_UD_BASE) begin
            rel  = a - page_select_pkg::OFS_UD_BASE;
            user = 1'b1;
        end else begin
            rel = a - page_select_pkg::OFS_CS_BASE;
        end
        valid = (32'(rel) < NBYTES);
        return {1'b0, rel};
    endfunction

    // Bits enter in transmission order: stored MSB is bit 0
    function automatic logic [7:0] crc_byte(input logic [7:0] crc, input logic [7:0] d);
        logic [7:0] c;
        logic       fb;
        c  = crc;
        fb = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            fb = c[7] ^ d[i];
            c  = {c[6:0], 1'b0} ^ (fb ? page_select_pkg::CRC_POLY : page_select_pkg::READ_ZERO);
        end
        return c;
    endfunction

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [7:0]  rx_cs_r [NBYTES];
    logic [7:0]  rx_ud_r [NBYTES];
    logic [7:0]  tx_cs_r [NBYTES];
    logic [7:0]  tx_ud_r [NBYTES];
    logic [15:0] burst_len_r;
    logic [1:0]  bank_r;
    logic [7:0]  rdata_r;
    logic        rvalid_r;
    logic [7:0]  tx_data_r;
    logic [1:0]  prof_r;
    logic [4:0]  crc_idx_r;
    logic        crc_ch_r;
    logic [7:0]  crc_acc_r;
    logic [7:0]  crc_res_r [2];

    logic [7:0]  h_slot;
    logic        h_valid;
    logic        h_user;
    logic [7:0]  t_slot;
    logic        t_valid;
    logic        t_user;
    logic        h_bank_hit;

    always_comb begin
        h_slot     = buf_slot(reg_addr, h_valid, h_user);
        t_slot     = buf_slot(tx_rd_addr, t_valid, t_user);
        h_bank_hit = (reg_addr == page_select_pkg::OFS_BANK_SEL);
    end

    // ------------------------------------------------------------
    // Bank selector
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            bank_r <= page_select_pkg::BANK_CTRL;
        end else if (reg_wr && h_bank_hit) begin
            // Decoded ahead of the page so it is never stranded
            bank_r <= reg_wdata[1:0];
        end
    end

    // ------------------------------------------------------------
    // Burst length capture
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            burst_len_r <= 16'h0000;
        end else if (rx_burst_valid) begin
            burst_len_r <= rx_burst_length_word;
        end
    end

    // ------------------------------------------------------------
    // Buffers: receiver side from the decoder, transmitter side from host
    // ------------------------------------------------------------
    logic        r_valid;
    logic        r_user;
    logic [7:0]  r_slot;
    always_comb begin
        r_slot = buf_slot(rx_buf_addr, r_valid, r_user);
    end

    // Receiver writes win over host writes to the same page
    always_ff @(posedge clk_sys) begin
        if (rx_buf_wr && r_valid) begin
            if (r_user) begin
                rx_ud_r[r_slot[5:0]] <= rx_buf_data;
            end else begin
                rx_cs_r[r_slot[5:0]] <= rx_buf_data;
            end
        end else if (reg_wr && !h_bank_hit && h_valid && bank_r == page_select_pkg::BANK_RX) begin
            if (h_user) begin
                rx_ud_r[h_slot[5:0]] <= reg_wdata;
            end else begin
                rx_cs_r[h_slot[5:0]] <= reg_wdata;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reg_wr && !h_bank_hit && h_valid && bank_r == page_select_pkg::BANK_TX) begin
            if (h_user) begin
                tx_ud_r[h_slot[5:0]] <= reg_wdata;
            end else begin
                tx_cs_r[h_slot[5:0]] <= reg_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Professional mode CRC walker
    // ------------------------------------------------------------
    // One byte a cycle; a new CRC lands every 23 cycles, alternating channels,
    // so every 46 cycles per channel, and a host edit is reflected within about 69 cycles.
    logic [7:0] crc_nxt;
    always_comb begin
        crc_nxt = crc_byte(crc_acc_r, tx_cs_r[{crc_idx_r, crc_ch_r}]);
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            crc_idx_r    <= 5'd0;
            crc_ch_r     <= 1'b0;
            crc_acc_r    <= page_select_pkg::CRC_INIT;
            crc_res_r[0] <= page_select_pkg::CRC_INIT;
            crc_res_r[1] <= page_select_pkg::CRC_INIT;
        end else if (crc_idx_r == page_select_pkg::CRC_LAST_IDX) begin
            crc_res_r[crc_ch_r] <= crc_nxt;
            crc_acc_r           <= page_select_pkg::CRC_INIT;
            crc_idx_r           <= 5'd0;
            crc_ch_r            <= ~crc_ch_r;
        end else begin
            crc_acc_r <= crc_nxt;
            crc_idx_r <= crc_idx_r + 5'd1;
        end
    end

    // ------------------------------------------------------------
    // Transmitter read port
    // ------------------------------------------------------------
    logic t_crc_slot;
    always_comb begin
        t_crc_slot = t_valid && !t_user && (t_slot[5:1] == page_select_pkg::CRC_BYTE_IDX);
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tx_data_r <= page_select_pkg::READ_ZERO;
            prof_r    <= 2'b00;
        end else begin
            prof_r <= {tx_cs_r[1][page_select_pkg::MODE_BIT], tx_cs_r[0][page_select_pkg::MODE_BIT]};
            if (!t_valid) begin
                tx_data_r <= page_select_pkg::READ_ZERO;
            end else if (t_user) begin
                tx_data_r <= tx_ud_r[t_slot[5:0]];
            end else if (t_crc_slot && tx_cs_r[t_slot[0]][page_select_pkg::MODE_BIT]) begin
                tx_data_r <= crc_res_r[t_slot[0]];
            end else begin
                tx_data_r <= tx_cs_r[t_slot[5:0]];
            end
        end
    end

    // ------------------------------------------------------------
    // Host read mux
    // ------------------------------------------------------------
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = page_select_pkg::READ_ZERO;
        if (h_bank_hit) begin
            rd_mux = {6'b000000, bank_r} & page_select_pkg::BANK_BYTE_MASK;
        end else begin
            case (bank_r)
                page_select_pkg::BANK_CTRL: begin
                    if (reg_addr == page_select_pkg::OFS_BURST_HIGH) begin
                        rd_mux = burst_len_r[15:8];
                    end else if (reg_addr == page_select_pkg::OFS_BURST_LOW) begin
                        rd_mux = burst_len_r[7:0];
                    end
                end
                page_select_pkg::BANK_RX: begin
                    if (h_valid) begin
                        rd_mux = h_user ? rx_ud_r[h_slot[5:0]] : rx_cs_r[h_slot[5:0]];
                    end
                end
                page_select_pkg::BANK_TX: begin
                    if (h_valid) begin
                        rd_mux = h_user ? tx_ud_r[h_slot[5:0]] : tx_cs_r[h_slot[5:0]];
                    end
                end
                default: begin
                    rd_mux = page_select_pkg::READ_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rdata_r  <= page_select_pkg::READ_ZERO;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= reg_rd;
            if (reg_rd) begin
                rdata_r <= rd_mux;
            end
        end
    end

    assign reg_rdata       = rdata_r;
    assign reg_rvalid      = rvalid_r;
    assign bank_sel        = bank_r;
    assign tx_rd_data      = tx_data_r;
    assign tx_professional = prof_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_bank_write_any: assert property (@(posedge clk_sys) disable iff (!resetn)
        (reg_wr && reg_addr == page_select_pkg::OFS_BANK_SEL) |=> bank_sel == $past(reg_wdata[1:0]))
        else $error("bank selector write lost");
    a_bank_upper_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
        (reg_rd && reg_addr == page_select_pkg::OFS_BANK_SEL) |=> (reg_rdata[7:2] == 6'b000000 && reg_rvalid))
        else $error("bank selector upper bits not zero");
    a_burst_high_read: assert property (@(posedge clk_sys) disable iff (!resetn)
        (reg_rd && bank_sel == page_select_pkg::BANK_CTRL && reg_addr == page_select_pkg::OFS_BURST_HIGH)
        |=> reg_rdata == $past(burst_len_r[15:8]))
        else $error("burst high byte wrong");
    a_burst_low_read: assert property (@(posedge clk_sys) disable iff (!resetn)
        (reg_rd && bank_sel == page_select_pkg::BANK_CTRL && reg_addr == page_select_pkg::OFS_BURST_LOW)
        |=> reg_rdata == $past(burst_len_r[7:0]))
        else $error("burst low byte wrong");
    a_burst_capture: assert property (@(posedge clk_sys) disable iff (!resetn)
        rx_burst_valid |=> burst_len_r == $past(rx_burst_length_word))
        else $error("burst length not captured");
    a_reserved_bank: assert property (@(posedge clk_sys) disable iff (!resetn)
        (reg_rd && bank_sel == page_select_pkg::BANK_RSVD && reg_addr != page_select_pkg::OFS_BANK_SEL)
        |=> reg_rdata == page_select_pkg::READ_ZERO)
        else $error("reserved bank read not zero");
    // Triggered by a byte 0 write so unwritten buffer contents never reach the compare
    a_tx_mode_bit: assert property (@(posedge clk_sys) disable iff (!resetn)
        (reg_wr && bank_sel == page_select_pkg::BANK_TX && reg_addr == page_select_pkg::OFS_CS_BASE)
        |=> ##1 tx_professional[0] == $past(reg_wdata[page_select_pkg::MODE_BIT], 2))
        else $error("professional flag wrong");
    a_crc_insert: assert property (@(posedge clk_sys) disable iff (!resetn)
        (tx_rd_addr == 7'({page_select_pkg::CRC_BYTE_IDX, 1'b0}) && tx_cs_r[0][page_select_pkg::MODE_BIT])
        |=> tx_rd_data == $past(crc_res_r[0]))
        else $error("CRC not inserted in byte 23");
    a_rx_bank_read: assert property (@(posedge clk_sys) disable iff (!resetn)
        (reg_rd && bank_sel == page_select_pkg::BANK_RX && reg_addr == 7'h01) |=> reg_rdata == $past(rx_cs_r[1]))
        else $error("receiver buffer read wrong");
endmodule

// file: verilog/page_select_pkg.sv
// Constants for the page select and burst length register bank
package page_select_pkg;
    localparam logic [6:0] OFS_BURST_HIGH = 7'h2B;
    localparam logic [6:0] OFS_BURST_LOW  = 7'h2C;
    localparam logic [6:0] OFS_BANK_SEL   = 7'h7F;
    localparam logic [6:0] OFS_CS_BASE    = 7'h00;
    localparam logic [6:0] OFS_UD_BASE    = 7'h40;
    localparam int         STATUS_BYTES   = 24;
    localparam int         BUF_BYTES      = 2 * STATUS_BYTES;
    localparam logic [4:0] CRC_BYTE_IDX   = 5'd23;
    localparam logic [4:0] CRC_LAST_IDX   = 5'd22;
    localparam logic [7:0] CRC_INIT       = 8'hFF;
    localparam logic [7:0] CRC_POLY       = 8'h1D;
    localparam int         MODE_BIT       = 7;
    localparam logic [7:0] BANK_BYTE_MASK = 8'h03;
    localparam logic [7:0] READ_ZERO      = 8'h00;

    typedef enum logic [1:0] {
        BANK_CTRL = 2'b00,
        BANK_RX   = 2'b01,
        BANK_RSVD = 2'b11,
        BANK_TX   = 2'b10
    } bank_t;
endpackage
